/* logic/xps_regs.svh */
// Purpose: Shared constants of the crosspoint switch control link
// Assumes: Included by bare name from the package and the two ends
// Notes: Timing counts are derived from the 40 MHz reference clock
`ifndef XPS_REGS_SVH
`define XPS_REGS_SVH

// Number of amplifiers and width of a channel code
`define XPS_NUM_AMPS 4
`define XPS_CH_W 4
`define XPS_AMP_W 2
`define XPS_FRAME_W 16

// Channel code with the disable bit set, held after power-on
`define XPS_CH_DISABLED 4'h8
`define XPS_CH_DIS_BIT 3

// Serial frame layout, first bit shifted is bit 15
`define XPS_FRM_AMP_LSB 0
`define XPS_FRM_CH_LSB 2
`define XPS_FRM_UPD_BIT 6

// Controller register byte offsets on the Avalon-MM slave
`define XPS_REG_PAR 4'h0
`define XPS_REG_SER 4'h4
`define XPS_REG_STAT 4'h8
`define XPS_REG_CTRL 4'hC

// Field positions inside the controller registers
`define XPS_PAR_CH_LSB 0
`define XPS_PAR_AMP_LSB 4
`define XPS_PAR_UPD_BIT 6
`define XPS_STAT_BUSY_BIT 0
`define XPS_STAT_RX_LSB 16
`define XPS_CTRL_PD_BIT 0

// Timing: reference clock and serial clock ceiling in kHz
`define XPS_REF_CLK_KHZ 40000
`define XPS_SCLK_MAX_KHZ 2000
// Half period of the serial clock, rounded up so the rate stays under the ceiling
`define XPS_SCLK_HALF_CYC ((`XPS_REF_CLK_KHZ + 2 * `XPS_SCLK_MAX_KHZ - 1) / (2 * `XPS_SCLK_MAX_KHZ))
// Parallel strobe width and data setup/hold, in reference cycles
`define XPS_STROBE_CYC 6

`endif

/* logic/xps_pkg.sv */
// Purpose: Types of the crosspoint switch control link
// Assumes: Constants come from xps_regs.svh
// Notes: Host sequencer states are one-hot
`include "xps_regs.svh"

package xps_pkg;

    // Host sequencer states
    typedef enum logic [8:0] {
        ST_IDLE     = 9'b0_0000_0001,
        ST_P_SETUP  = 9'b0_0000_0010,
        ST_P_STROBE = 9'b0_0000_0100,
        ST_P_HOLD   = 9'b0_0000_1000,
        ST_P_UPDATE = 9'b0_0001_0000,
        ST_S_SEL    = 9'b0_0010_0000,
        ST_S_HIGH   = 9'b0_0100_0000,
        ST_S_LOW    = 9'b0_1000_0000,
        ST_S_DONE   = 9'b1_0000_0000
    } xps_state_e;

    typedef logic [`XPS_CH_W-1:0] xps_ch_t;

endpackage

/* logic/xps_if.sv */
// Purpose: Logic pins between the crosspoint device and its host
// Assumes: Host drives every pin but the serial output
// Notes: No clock travels with it; both ends sample on their own clock
`timescale 1ns/1ps
`default_nettype none

interface xps_if;
    logic wr_b;
    logic ce_b;
    logic update_b;
    logic [3:0] channel_sel;
    logic [1:0] amp_sel;
    logic cs_b;
    logic sclk;
    logic din;
    logic dout;
    logic power_down;

    modport dev (
        input wr_b, ce_b, update_b, channel_sel, amp_sel, cs_b, sclk, din, power_down,
        output dout
    );
    modport host (
        output wr_b, ce_b, update_b, channel_sel, amp_sel, cs_b, sclk, din, power_down,
        input dout
    );
endinterface

`default_nettype wire

/* logic/xps_sync.sv */
// Purpose: Two-flop synchroniser for a bundle of pin levels
// Assumes: Each bit is an independent level from another domain
// Notes: Only the second stage is visible to the caller
`timescale 1ns/1ps
`default_nettype none

module xps_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // First stage feeds the second and nothing else
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            meta_q <= RST_VAL;
            sync_out <= RST_VAL;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

`default_nettype wire

/* logic/xps_device.sv */
// Purpose: Control logic of an 8-input, 4-output crosspoint switch
// Assumes: All link pins are asynchronous to ref_clk and are synchronised
// Notes: Amplifier enables and channel codes drive the analog array
//
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "xps_regs.svh"

module xps_device #(
    parameter int NUM_AMPS = `XPS_NUM_AMPS,
    parameter int FRAME_W = `XPS_FRAME_W
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    xps_if.dev link,
    output logic [NUM_AMPS-1:0] amp_enable_q,
    output logic [NUM_AMPS*3-1:0] amp_channel_q,
    output logic amp_power_q
);
    localparam int CH_W = `XPS_CH_W;
    localparam int AMP_W = `XPS_AMP_W;
    localparam int SYNC_W = 7 + AMP_W + CH_W;
    // Strobes and select idle high, everything else low
    localparam logic [SYNC_W-1:0] SYNC_RST = {4'h0, 2'h0, 1'b0, 1'b0, 1'b0, 4'hF};

    // Synchronised pin levels
    logic [SYNC_W-1:0] pins_s;
    logic wr_b_s;
    logic ce_b_s;
    logic update_b_s;
    logic cs_b_s;
    logic sclk_s;
    logic din_s;
    logic power_down_s;
    logic [AMP_W-1:0] amp_sel_s;
    logic [CH_W-1:0] channel_sel_s;

    // Edge history and serial state
    logic sclk_p_q;
    logic cs_b_p_q;
    logic [FRAME_W-1:0] shift_q;
    logic [FRAME_W-1:0] shift_d;
    logic [4:0] bit_cnt_q;
    logic [4:0] bit_cnt_d;
    logic dout_q;
    logic dout_d;
    logic ser_upd_q;
    logic ser_upd_d;

    // Register banks
    logic [NUM_AMPS-1:0][CH_W-1:0] in_q;
    logic [NUM_AMPS-1:0][CH_W-1:0] in_d;
    logic [NUM_AMPS-1:0][CH_W-1:0] sw_q;
    logic [NUM_AMPS-1:0][CH_W-1:0] sw_d;

    // Every pin crosses through two flops before any decode
    xps_sync #(
        .W(SYNC_W),
        .RST_VAL(SYNC_RST)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .async_in({link.channel_sel, link.amp_sel, link.power_down, link.din, link.sclk,
                   link.cs_b, link.update_b, link.ce_b, link.wr_b}),
        .sync_out(pins_s)
    );

    assign wr_b_s = pins_s[0];
    assign ce_b_s = pins_s[1];
    assign update_b_s = pins_s[2];
    assign cs_b_s = pins_s[3];
    assign sclk_s = pins_s[4];
    assign din_s = pins_s[5];
    assign power_down_s = pins_s[6];
    assign amp_sel_s = pins_s[7 +: AMP_W];
    assign channel_sel_s = pins_s[7+AMP_W +: CH_W];

    // Mode decode; the parallel path needs strobe and enable both low
    logic par_write;
    logic ser_mode;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_release;
    logic frame_full;
    logic ser_apply;
    assign par_write = !wr_b_s && !ce_b_s;
    // Serial decode only with every parallel strobe idle, so a stray clock in parallel use does nothing
    assign ser_mode = !cs_b_s && wr_b_s && ce_b_s && update_b_s;
    assign sclk_rise = ser_mode && sclk_s && !sclk_p_q;
    // Falling edges are honoured only while the select is low
    assign sclk_fall = !cs_b_s && !sclk_s && sclk_p_q;
    assign cs_release = cs_b_s && !cs_b_p_q;
    assign frame_full = (bit_cnt_q >= 5'(FRAME_W));
    // A short frame is dropped rather than applied half-shifted
    assign ser_apply = cs_release && frame_full;

    // Fixed field positions inside the last sixteen bits
    logic [AMP_W-1:0] frm_amp;
    logic [CH_W-1:0] frm_ch;
    logic frm_upd;
    assign frm_amp = shift_q[`XPS_FRM_AMP_LSB +: AMP_W];
    assign frm_ch = shift_q[`XPS_FRM_CH_LSB +: CH_W];
    assign frm_upd = shift_q[`XPS_FRM_UPD_BIT];

    // Shift register and bit counter on sampled rising edges
    always_comb
    begin
        shift_d = shift_q;
        bit_cnt_d = bit_cnt_q;
        if (cs_b_s)
        begin
            bit_cnt_d = 5'h0;
        end
        else if (sclk_rise)
        begin
            shift_d = {shift_q[FRAME_W-2:0], din_s};
            if (!frame_full)
            begin
                bit_cnt_d = bit_cnt_q + 5'h1;
            end
        end
    end

    // Oldest bit leaves on the falling edge after its sixteenth rise;
    // with the select high nothing moves and the pin keeps its last level
    always_comb
    begin
        dout_d = dout_q;
        if (sclk_fall)
        begin
            dout_d = shift_q[FRAME_W-1];
        end
    end

    // A frame with the update flag moves all switch registers one cycle later,
    // after its own input register has settled
    assign ser_upd_d = ser_apply && frm_upd;

    // Input and switch register banks, one slot per amplifier
    genvar gi;
    generate
        for (gi = 0; gi < NUM_AMPS; gi++)
        begin : g_amp
            logic par_hit;
            logic ser_hit;
            assign par_hit = par_write && (amp_sel_s == AMP_W'(gi));
            assign ser_hit = ser_apply && (frm_amp == AMP_W'(gi));
            // Loading ignores the shutdown level so a new setup can be staged
            assign in_d[gi] = par_hit ? channel_sel_s : (ser_hit ? frm_ch : in_q[gi]);
            // Transparent while update is low, which also covers its falling edge
            assign sw_d[gi] = (!update_b_s || ser_upd_q) ? in_q[gi] : sw_q[gi];
        end
    endgenerate

    // Register banks come up disabled after reset
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            in_q <= {NUM_AMPS{`XPS_CH_DISABLED}};
            sw_q <= {NUM_AMPS{`XPS_CH_DISABLED}};
        end
        else
        begin
            in_q <= in_d;
            sw_q <= sw_d;
        end
    end

    // Serial state and edge history
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            sclk_p_q <= 1'b0;
            cs_b_p_q <= 1'b1;
            shift_q <= '0;
            bit_cnt_q <= 5'h0;
            dout_q <= 1'b0;
            ser_upd_q <= 1'b0;
        end
        else
        begin
            sclk_p_q <= sclk_s;
            cs_b_p_q <= cs_b_s;
            shift_q <= shift_d;
            bit_cnt_q <= bit_cnt_d;
            dout_q <= dout_d;
            ser_upd_q <= ser_upd_d;
        end
    end

    // The serial output is always driven, never released
    assign link.dout = dout_q;

    // Amplifier controls; shutdown is active high and gates every enable
    logic [NUM_AMPS-1:0] amp_enable_d;
    logic [NUM_AMPS*3-1:0] amp_channel_d;
    generate
        for (gi = 0; gi < NUM_AMPS; gi++)
        begin : g_out
            // A cleared enable puts the amplifier output in high impedance
            assign amp_enable_d[gi] = !sw_q[gi][`XPS_CH_DIS_BIT] && !power_down_s;
            assign amp_channel_d[gi*3 +: 3] = sw_q[gi][2:0];
        end
    endgenerate

    // Output flops, all amplifiers off after reset
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            amp_enable_q <= '0;
            amp_channel_q <= '0;
            amp_power_q <= 1'b0;
        end
        else
        begin
            amp_enable_q <= amp_enable_d;
            amp_channel_q <= amp_channel_d;
            amp_power_q <= !power_down_s;
        end
    end
endmodule

`default_nettype wire

/* logic/xps_host.sv */
// Purpose: Host controller that drives the crosspoint logic pins
// Assumes: Software reaches it over Avalon-MM with waitrequest
// Notes: Serial clock is divided down from ref_clk and driven out
`timescale 1ns/1ps
`default_nettype none
`include "xps_regs.svh"

module xps_host #(
    parameter int SCLK_HALF = `XPS_SCLK_HALF_CYC,
    parameter int STROBE = `XPS_STROBE_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    xps_if.host link
);
    xps_pkg::xps_state_e state_q;
    xps_pkg::xps_state_e state_d;
    logic [7:0] cnt_q;
    logic [4:0] bits_q;
    logic [15:0] tx_q;
    logic [15:0] rx_q;
    logic [6:0] par_q;
    logic pd_q;
    logic wr_b_q;
    logic ce_b_q;
    logic update_b_q;
    logic cs_b_q;
    logic sclk_q;
    logic din_q;
    logic dout_s;

    // Serial output of the device is foreign to ref_clk
    xps_sync #(
        .W(1),
        .RST_VAL(1'b0)
    ) u_dout_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .async_in(link.dout),
        .sync_out(dout_s)
    );

    // Bus decode; a command write waits while a transfer runs
    logic busy;
    logic req;
    logic cmd_hit;
    logic take;
    logic cnt_done;
    logic [31:0] rd_mux;
    assign busy = (state_q != xps_pkg::ST_IDLE);
    assign req = (avs_read || avs_write) && avs_waitrequest;
    assign cmd_hit = avs_write && (avs_address == `XPS_REG_PAR || avs_address == `XPS_REG_SER);
    assign take = req && !(cmd_hit && busy);
    assign cnt_done = (cnt_q == 8'h0);
    assign rd_mux = (avs_address == `XPS_REG_PAR) ? {25'h0, par_q} :
                    (avs_address == `XPS_REG_SER) ? {16'h0, tx_q} :
                    (avs_address == `XPS_REG_STAT) ? {rx_q, 15'h0, busy} :
                    (avs_address == `XPS_REG_CTRL) ? {31'h0, pd_q} : 32'h0;

    // Sequencer next state
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            xps_pkg::ST_IDLE:
            begin
                if (take && avs_write && avs_address == `XPS_REG_PAR)
                    state_d = xps_pkg::ST_P_SETUP;
                else if (take && avs_write && avs_address == `XPS_REG_SER)
                    state_d = xps_pkg::ST_S_SEL;
            end
            xps_pkg::ST_P_SETUP: if (cnt_done) state_d = xps_pkg::ST_P_STROBE;
            xps_pkg::ST_P_STROBE: if (cnt_done) state_d = xps_pkg::ST_P_HOLD;
            xps_pkg::ST_P_HOLD:
            begin
                if (cnt_done)
                    state_d = par_q[`XPS_PAR_UPD_BIT] ? xps_pkg::ST_P_UPDATE : xps_pkg::ST_IDLE;
            end
            xps_pkg::ST_P_UPDATE: if (cnt_done) state_d = xps_pkg::ST_IDLE;
            xps_pkg::ST_S_SEL: if (cnt_done) state_d = xps_pkg::ST_S_HIGH;
            // Sixteen full clock periods, so the oldest bit still leaves the chain on a fall
            xps_pkg::ST_S_HIGH: if (cnt_done) state_d = xps_pkg::ST_S_LOW;
            xps_pkg::ST_S_LOW:
            begin
                if (cnt_done)
                    state_d = (bits_q == 5'h10) ? xps_pkg::ST_S_DONE : xps_pkg::ST_S_HIGH;
            end
            xps_pkg::ST_S_DONE: if (cnt_done) state_d = xps_pkg::ST_IDLE;
            default: state_d = xps_pkg::ST_IDLE;
        endcase
    end

    // Every phase lasts a fixed count; serial phases keep the clock under its ceiling
    logic [7:0] phase_len;
    logic serial_st;
    assign serial_st = (state_d == xps_pkg::ST_S_SEL) || (state_d == xps_pkg::ST_S_HIGH) ||
                       (state_d == xps_pkg::ST_S_LOW) || (state_d == xps_pkg::ST_S_DONE);
    assign phase_len = serial_st ? 8'(SCLK_HALF - 1) : 8'(STROBE - 1);

    // Bus slave: answer one cycle after the request is taken
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
            par_q <= {3'h0, `XPS_CH_DISABLED};
            pd_q <= 1'b0;
        end
        else
        begin
            avs_waitrequest <= !take;
            if (take && avs_read)
                avs_readdata <= rd_mux;
            if (take && avs_write && avs_address == `XPS_REG_PAR)
                par_q <= avs_writedata[6:0];
            if (take && avs_write && avs_address == `XPS_REG_CTRL)
                pd_q <= avs_writedata[`XPS_CTRL_PD_BIT];
        end
    end

    // Sequencer registers and pin drive
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            state_q <= xps_pkg::ST_IDLE;
            cnt_q <= 8'h0;
            bits_q <= 5'h0;
            tx_q <= 16'h0;
            rx_q <= 16'h0;
            wr_b_q <= 1'b1;
            ce_b_q <= 1'b1;
            update_b_q <= 1'b1;
            cs_b_q <= 1'b1;
            sclk_q <= 1'b0;
            din_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= (state_d != state_q) ? phase_len : (cnt_done ? 8'h0 : cnt_q - 8'h1);
            // Parallel strobes; select stays high and clock/data low
            wr_b_q <= (state_d != xps_pkg::ST_P_STROBE);
            ce_b_q <= (state_d != xps_pkg::ST_P_STROBE);
            update_b_q <= (state_d != xps_pkg::ST_P_UPDATE);
            // Serial: strobes idle high while the select is low
            cs_b_q <= !(state_d == xps_pkg::ST_S_SEL || state_d == xps_pkg::ST_S_HIGH ||
                        state_d == xps_pkg::ST_S_LOW);
            sclk_q <= (state_d == xps_pkg::ST_S_HIGH);
            if (state_q == xps_pkg::ST_IDLE && state_d == xps_pkg::ST_S_SEL)
            begin
                tx_q <= avs_writedata[15:0];
                din_q <= avs_writedata[15];
                bits_q <= 5'h0;
            end
            // Whole frame in one transfer, first bit is the top bit
            if (state_q == xps_pkg::ST_S_HIGH && state_d == xps_pkg::ST_S_LOW)
            begin
                // After the sixteenth bit the index wraps to a harmless don't-care bit
                din_q <= tx_q[4'(14 - bits_q[3:0])];
                bits_q <= bits_q + 5'h1;
            end
            if (state_q == xps_pkg::ST_S_HIGH && state_d != xps_pkg::ST_S_HIGH)
                rx_q <= {rx_q[14:0], dout_s};
            if (state_d == xps_pkg::ST_IDLE || state_d == xps_pkg::ST_S_DONE)
                din_q <= 1'b0;
        end
    end

    assign link.wr_b = wr_b_q;
    assign link.ce_b = ce_b_q;
    assign link.update_b = update_b_q;
    assign link.cs_b = cs_b_q;
    assign link.sclk = sclk_q;
    assign link.din = din_q;
    assign link.power_down = pd_q;
    assign link.amp_sel = par_q[`XPS_PAR_AMP_LSB +: 2];
    assign link.channel_sel = par_q[`XPS_PAR_CH_LSB +: 4];
endmodule

`default_nettype wire

/* testbench/xps_link_props.sv */
// Purpose: Concurrent checks on the pins between crosspoint host and device
// Assumes: Default strobe width of six cycles and serial half period of ten
// Notes: Device-side checks leave room for its pin synchroniser lag
`timescale 1ns/1ps
`default_nettype none

module xps_link_props (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic wr_b,
    input wire logic ce_b,
    input wire logic update_b,
    input wire logic [3:0] channel_sel,
    input wire logic [1:0] amp_sel,
    input wire logic cs_b,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout,
    input wire logic power_down
);
    logic sclk_q;
    logic [4:0] rise_q;

    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    // Serial clock rises inside one select-low frame; cleared while select is high
    always_ff @(posedge ref_clk)
    begin
        sclk_q <= sclk;
        rise_q <= (!rst_b || cs_b) ? 5'h00 : rise_q + 5'(sclk && !sclk_q);
    end

    property p_par_quiet; !wr_b |-> cs_b && !sclk && !din; endproperty
    a_par_quiet: assert property (p_par_quiet) else $error("serial pins busy in parallel write");
    property p_ser_mode; !cs_b |-> wr_b && ce_b && update_b; endproperty
    a_ser_mode: assert property (p_ser_mode) else $error("strobe low in serial mode");
    property p_strobe; $fell(wr_b) |-> $fell(ce_b) ##0 (!wr_b && !ce_b) [*6] ##1 (wr_b && ce_b); endproperty
    a_strobe: assert property (p_strobe) else $error("write strobe pair malformed");
    property p_data_hold; !wr_b |-> $stable(channel_sel) && $stable(amp_sel); endproperty
    a_data_hold: assert property (p_data_hold) else $error("data moved during strobe");
    property p_upd_sep; !update_b |-> wr_b && ce_b && cs_b; endproperty
    a_upd_sep: assert property (p_upd_sep) else $error("update overlaps a write");
    property p_upd_width; $fell(update_b) |-> (!update_b) [*6] ##1 update_b; endproperty
    a_upd_width: assert property (p_upd_width) else $error("update pulse width wrong");
    // Eight stable samples after each change, so each level holds at least nine cycles
    property p_sclk_rate; $changed(sclk) |=> $stable(sclk) [*8]; endproperty
    a_sclk_rate: assert property (p_sclk_rate) else $error("serial clock too fast");
    property p_frame_len; $rose(cs_b) |-> rise_q == 5'h10; endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame not sixteen bits");
    property p_dout_edge; $changed(dout) |-> !sclk && (!cs_b || !$past(cs_b, 4)); endproperty
    a_dout_edge: assert property (p_dout_edge) else $error("serial output moved off a fall");
    property p_dout_hold; cs_b && $past(cs_b, 6) |-> $stable(dout); endproperty
    a_dout_hold: assert property (p_dout_hold) else $error("serial output moved while idle");

    c_frame: cover property ($rose(cs_b));
    c_write: cover property ($fell(wr_b));
    c_update: cover property ($rose(update_b));
endmodule

`default_nettype wire

/* testbench/tb_top.sv */
// Purpose: Self-checking bench for host and device joined by the link
// Assumes: Default strobe and serial clock counts; slave answers after one cycle
// Notes: Expected amplifier states live in two arrays updated per scenario
`timescale 1ns/1ps
`default_nettype none
`include "xps_regs.svh"

module tb_top;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [3:0] amp_enable_q;
    logic [11:0] amp_channel_q;
    logic amp_power_q;
    logic [31:0] rd;
    logic [3:0] exp_en;
    logic [11:0] exp_ch;
    logic [11:0] msk;
    int bad_count = 0;
    int checks = 0;

    xps_if u_xps_if ();
    xps_host u_xps_host (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .link(u_xps_if));
    xps_device u_xps_device (.ref_clk(ref_clk), .rst_b(rst_b), .link(u_xps_if), .amp_enable_q(amp_enable_q),
        .amp_channel_q(amp_channel_q), .amp_power_q(amp_power_q));
    xps_link_props u_xps_link_props (.ref_clk(ref_clk), .rst_b(rst_b), .wr_b(u_xps_if.wr_b),
        .ce_b(u_xps_if.ce_b), .update_b(u_xps_if.update_b), .channel_sel(u_xps_if.channel_sel),
        .amp_sel(u_xps_if.amp_sel), .cs_b(u_xps_if.cs_b), .sclk(u_xps_if.sclk), .din(u_xps_if.din),
        .dout(u_xps_if.dout), .power_down(u_xps_if.power_down));

    // Reference clock, 25 ns period
    always #12.5 ref_clk = ~ref_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One bus transfer; held until waitrequest is sampled low, then one idle edge
    task automatic av(input logic wr, input logic [3:0] addr, input logic [31:0] data);
        avs_address <= addr;
        avs_writedata <= data;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge ref_clk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask

    // Poll busy, then allow for the device synchroniser and apply latency
    task automatic settle();
        int n = 0;
        rd = 32'h0000_0001;
        while (rd[0] !== 1'b0 && n < 400)
        begin
            av(1'b0, `XPS_REG_STAT, 32'h0000_0000);
            n++;
        end
        // A host that never goes idle counts as a mismatch
        check(32'(rd[0]), 32'h0000_0000);
        repeat (12) @(posedge ref_clk);
    endtask

    task automatic par(input logic [1:0] amp, input logic [3:0] ch, input logic upd);
        av(1'b1, `XPS_REG_PAR, {25'h000_0000, upd, amp, ch});
        settle();
    endtask

    // Channel fields of disabled amplifiers are left unchecked
    task automatic amps();
        msk = {{3{exp_en[3]}}, {3{exp_en[2]}}, {3{exp_en[1]}}, {3{exp_en[0]}}};
        check(32'(amp_enable_q), 32'(exp_en));
        check(32'(amp_channel_q & msk), 32'(exp_ch & msk));
    endtask

    initial
    begin
        exp_en = 4'h0;
        exp_ch = 12'h000;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        check(32'(amp_enable_q), 32'h0000_0000);
        av(1'b0, `XPS_REG_CTRL, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        av(1'b0, 4'h2, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        check(32'(amp_power_q), 32'h0000_0001);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            par(2'(i), 4'(i), 1'b1);
            exp_en[i % 4] = 1'b1;
            exp_ch[(i % 4) * 3 +: 3] = 3'(i);
            amps();
        end
        $display("test parallel done");
        par(2'h0, 4'h2, 1'b0);
        par(2'h1, 4'h1, 1'b0);
        amps();
        par(2'h2, 4'h8, 1'b1);
        exp_ch[5:0] = 6'h0a;
        exp_en[2] = 1'b0;
        amps();
        $display("test update done");
        av(1'b1, `XPS_REG_CTRL, 32'h0000_0001);
        repeat (8) @(posedge ref_clk);
        check(32'(amp_power_q), 32'h0000_0000);
        par(2'h3, 4'h0, 1'b1);
        check(32'(amp_enable_q), 32'h0000_0000);
        av(1'b1, `XPS_REG_CTRL, 32'h0000_0000);
        repeat (8) @(posedge ref_clk);
        exp_ch[11:9] = 3'h0;
        amps();
        $display("test shutdown done");
        av(1'b1, `XPS_REG_SER, 32'h0000_8051);
        settle();
        exp_en[1] = 1'b1;
        exp_ch[5:3] = 3'h4;
        amps();
        av(1'b1, `XPS_REG_SER, 32'h0000_0060);
        settle();
        exp_en[0] = 1'b0;
        amps();
        check(32'(rd[31:16]), 32'h0000_8051);
        $display("test serial done");
        final_report();
    end

    // Watchdog: the sequence needs under two thousand cycles, this allows twenty thousand
    initial
    begin
        #500000;
        bad_count++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        final_report();
    end
endmodule

`default_nettype wire
